/* File: include/dci_pkg.sv */
package dci_pkg;
  localparam int DCI_AW = 8;
  localparam int DCI_DW = 32;
  localparam int DCI_SW = 16;
  localparam int DCI_NFLAG = 8;
  localparam int DCI_NDET = 6;
  // Register offsets, byte addresses
  localparam logic [7:0] DCI_OFF_IRQ = 8'h00;
  localparam logic [7:0] DCI_OFF_SSA = 8'h04;
  localparam logic [7:0] DCI_OFF_SSIZ = 8'h08;
  localparam logic [7:0] DCI_OFF_DSIZ = 8'h0c;
  localparam logic [7:0] DCI_OFF_CSIZ = 8'h10;
  localparam logic [7:0] DCI_OFF_ACTL = 8'h14;
  // Field positions
  localparam int DCI_EN_LSB = 16;
  localparam int DCI_FLAG_LSB = 0;
  localparam int DCI_F_SRC_DONE = 7;
  localparam int DCI_F_SRC_HALF = 6;
  localparam int DCI_F_DST_DONE = 5;
  localparam int DCI_F_DST_HALF = 4;
  localparam int DCI_F_BLOCK = 3;
  localparam int DCI_F_CELL = 2;
  localparam int DCI_F_ABORT = 1;
  localparam int DCI_F_ADDR_ERR = 0;
  localparam int DCI_ACTL_EN = 0;
  localparam int DCI_ACTL_NUM_LSB = 8;
  // Pointer comparator slots
  localparam int DCI_D_SRC_DONE = 0;
  localparam int DCI_D_SRC_HALF = 1;
  localparam int DCI_D_DST_DONE = 2;
  localparam int DCI_D_DST_HALF = 3;
  localparam int DCI_D_BLOCK = 4;
  localparam int DCI_D_CELL = 5;
  // Reset values
  localparam logic [7:0] DCI_FLAG_RST = 8'h00;
  localparam logic [7:0] DCI_EN_RST = 8'h00;
  localparam logic [31:0] DCI_SSA_RST = 32'h0000_0000;
  localparam logic [15:0] DCI_SIZE_RST = 16'h0000;
  localparam logic [7:0] DCI_ANUM_RST = 8'hff;
  localparam logic DCI_AEN_RST = 1'b0;
  // Valid physical window for source start address
  localparam logic [31:0] DCI_ADDR_LO = 32'h0000_0000;
  localparam logic [31:0] DCI_ADDR_HI = 32'h1fff_ffff;

  typedef enum logic [1:0] {
    DCI_ST_IDLE = 2'b00,
    DCI_ST_ARMED = 2'b01,
    DCI_ST_ABORT = 2'b11
  } dci_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dci_bus_t;

  typedef struct packed {
    logic start;
    logic busy;
    logic src_step;
    logic [15:0] src_ptr;
    logic dst_step;
    logic [15:0] dst_ptr;
    logic cell_step;
    logic [15:0] cell_ptr;
    logic blk_step;
    logic [15:0] blk_cnt;
    logic pat_match;
    logic addr_err;
    logic irq_valid;
    logic [7:0] irq_num;
  } dci_evt_t;

  function automatic logic dci_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : dci_hit
endpackage : dci_pkg

/* File: verilog/dci_event_detect.sv */
`timescale 1ns/10ps
module dci_event_detect (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic clr_i, // New transfer, forget history
  input wire logic step_i, // Pointer updated
  input wire logic [15:0] ptr_i, // Current pointer
  input wire logic [15:0] tgt_i, // Compare target
  output logic hit_o // Pointer just became equal
);
  logic eq;
  logic eq_prev_r;
  logic eq_prev_nxt;

  // Fires once as the pointer arrives, not while it rests there
  assign eq = ptr_i == tgt_i;
  assign hit_o = ce_i & step_i & eq & ~eq_prev_r;
  assign eq_prev_nxt = clr_i ? 1'b0 : (step_i ? eq : eq_prev_r);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eq_prev_r <= 1'b0;
    end else if (ce_i) begin
      eq_prev_r <= eq_prev_nxt;
    end
  end
endmodule : dci_event_detect

/* File: verilog/dci_channel_irq.sv */
`timescale 1ns/10ps
// What this block does
// - Irq control bytes 31:24, 15:8 read zero
// - Enables in bits 23:16 match flags 7:0
// - Source done flag when pointer equals size
// - Source half flag at half source size
// - Destination done flag when pointer equals size
// - Destination half flag at half size
// - Block flag at larger size or pattern
// - Cell flag each finished cell
// - Abort flag after matching irq aborts transfer
// - Address error flag on invalid address
// - Source start address, 32 bits, resets zero
// - Source size is 16-bit byte count
// - Abort on matching irq only when enabled
module dci_channel_irq (
  input wire logic clock_i, // System clock, 200 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic ce_i, // Clock enable, low freezes all
  input wire dci_pkg::dci_bus_t bus_i, // Register request
  output logic [31:0] rdata_o, // Read data, cycle after read
  input wire dci_pkg::dci_evt_t evt_i, // Engine status and irqs
  output logic [31:0] ssa_o, // Source start address
  output logic [15:0] ssiz_o, // Source size
  output logic [15:0] dsiz_o, // Destination size
  output logic [15:0] csiz_o, // Cell size
  output logic abort_req_o, // Abort request to engine
  output logic irq_o // Channel interrupt, level
);
  import dci_pkg::*;

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic [31:0] ssa_r;
  logic [31:0] ssa_nxt;
  logic [15:0] ssiz_r;
  logic [15:0] ssiz_nxt;
  logic [15:0] dsiz_r;
  logic [15:0] dsiz_nxt;
  logic [15:0] csiz_r;
  logic [15:0] csiz_nxt;
  logic [7:0] anum_r;
  logic [7:0] anum_nxt;
  logic aen_r;
  logic aen_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  dci_state_t state_r;
  dci_state_t state_nxt;

  // Address decode
  logic sel_irq;
  logic sel_ssa;
  logic sel_ssiz;
  logic sel_dsiz;
  logic sel_csiz;
  logic sel_actl;
  logic wr_irq;
  logic [31:0] rd_mux;
  logic [31:0] irq_word;
  logic [31:0] actl_word;

  assign sel_irq = dci_hit(bus_i.addr, DCI_OFF_IRQ);
  assign sel_ssa = dci_hit(bus_i.addr, DCI_OFF_SSA);
  assign sel_ssiz = dci_hit(bus_i.addr, DCI_OFF_SSIZ);
  assign sel_dsiz = dci_hit(bus_i.addr, DCI_OFF_DSIZ);
  assign sel_csiz = dci_hit(bus_i.addr, DCI_OFF_CSIZ);
  assign sel_actl = dci_hit(bus_i.addr, DCI_OFF_ACTL);
  assign wr_irq = bus_i.wr & sel_irq;

  // Unimplemented bytes tie to zero
  assign irq_word = {8'h00, en_r, 8'h00, flags_r};
  assign actl_word = {16'h0000, anum_r, 7'h00, aen_r};

  assign rd_mux = sel_irq ? irq_word :
                  sel_ssa ? ssa_r :
                  sel_ssiz ? {16'h0000, ssiz_r} :
                  sel_dsiz ? {16'h0000, dsiz_r} :
                  sel_csiz ? {16'h0000, csiz_r} :
                  sel_actl ? actl_word : 32'h0000_0000;
  assign rdata_nxt = bus_i.rd ? rd_mux : 32'h0000_0000;

  // Register writes
  assign en_nxt = wr_irq ? bus_i.wdata[23:16] : en_r;
  assign ssa_nxt = (bus_i.wr & sel_ssa) ? bus_i.wdata : ssa_r;
  assign ssiz_nxt = (bus_i.wr & sel_ssiz) ? bus_i.wdata[15:0] : ssiz_r;
  assign dsiz_nxt = (bus_i.wr & sel_dsiz) ? bus_i.wdata[15:0] : dsiz_r;
  assign csiz_nxt = (bus_i.wr & sel_csiz) ? bus_i.wdata[15:0] : csiz_r;
  assign aen_nxt = (bus_i.wr & sel_actl) ? bus_i.wdata[DCI_ACTL_EN] : aen_r;
  assign anum_nxt = (bus_i.wr & sel_actl) ?
                    bus_i.wdata[DCI_ACTL_NUM_LSB +: 8] : anum_r;

  // Pointer comparators
  logic det_step [DCI_NDET];
  logic [15:0] det_ptr [DCI_NDET];
  logic [15:0] det_tgt [DCI_NDET];
  logic [DCI_NDET-1:0] det_hit;
  logic [15:0] blk_size;

  assign blk_size = (ssiz_r > dsiz_r) ? ssiz_r : dsiz_r;

  assign det_step[DCI_D_SRC_DONE] = evt_i.src_step;
  assign det_ptr[DCI_D_SRC_DONE] = evt_i.src_ptr;
  assign det_tgt[DCI_D_SRC_DONE] = ssiz_r;
  assign det_step[DCI_D_SRC_HALF] = evt_i.src_step;
  assign det_ptr[DCI_D_SRC_HALF] = evt_i.src_ptr;
  assign det_tgt[DCI_D_SRC_HALF] = ssiz_r >> 1;
  assign det_step[DCI_D_DST_DONE] = evt_i.dst_step;
  assign det_ptr[DCI_D_DST_DONE] = evt_i.dst_ptr;
  assign det_tgt[DCI_D_DST_DONE] = dsiz_r;
  assign det_step[DCI_D_DST_HALF] = evt_i.dst_step;
  assign det_ptr[DCI_D_DST_HALF] = evt_i.dst_ptr;
  assign det_tgt[DCI_D_DST_HALF] = dsiz_r >> 1;
  assign det_step[DCI_D_BLOCK] = evt_i.blk_step;
  assign det_ptr[DCI_D_BLOCK] = evt_i.blk_cnt;
  assign det_tgt[DCI_D_BLOCK] = blk_size;
  assign det_step[DCI_D_CELL] = evt_i.cell_step;
  assign det_ptr[DCI_D_CELL] = evt_i.cell_ptr;
  assign det_tgt[DCI_D_CELL] = csiz_r;

  genvar gi;
  generate
    for (gi = 0; gi < DCI_NDET; gi++) begin : g_det
      dci_event_detect u_det (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clr_i(evt_i.start),
        .step_i(det_step[gi]),
        .ptr_i(det_ptr[gi]),
        .tgt_i(det_tgt[gi]),
        .hit_o(det_hit[gi])
      );
    end
  endgenerate

  // Abort sequencer
  logic abort_hit;
  logic abort_done;

  assign abort_hit = aen_r & evt_i.busy & evt_i.irq_valid &
                     (evt_i.irq_num == anum_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DCI_ST_IDLE: begin
        if (abort_hit) begin
          state_nxt = DCI_ST_ABORT;
        end else if (aen_r & evt_i.busy) begin
          state_nxt = DCI_ST_ARMED;
        end
      end
      DCI_ST_ARMED: begin
        if (abort_hit) begin
          state_nxt = DCI_ST_ABORT;
        end else if (!(aen_r & evt_i.busy)) begin
          state_nxt = DCI_ST_IDLE;
        end
      end
      DCI_ST_ABORT: begin
        if (!evt_i.busy) begin
          state_nxt = DCI_ST_IDLE;
        end
      end
      default: begin
        state_nxt = DCI_ST_IDLE;
      end
    endcase
  end

  // Flag only once the engine has really stopped
  assign abort_done = (state_r == DCI_ST_ABORT) & ~evt_i.busy;
  assign abort_req_o = state_r == DCI_ST_ABORT;

  // Event flags
  logic ssa_bad;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  assign ssa_bad = (ssa_r < DCI_ADDR_LO) | (ssa_r > DCI_ADDR_HI);

  assign set_vec[DCI_F_SRC_DONE] = det_hit[DCI_D_SRC_DONE];
  assign set_vec[DCI_F_SRC_HALF] = det_hit[DCI_D_SRC_HALF];
  assign set_vec[DCI_F_DST_DONE] = det_hit[DCI_D_DST_DONE];
  assign set_vec[DCI_F_DST_HALF] = det_hit[DCI_D_DST_HALF];
  assign set_vec[DCI_F_BLOCK] = det_hit[DCI_D_BLOCK] | evt_i.pat_match;
  assign set_vec[DCI_F_CELL] = det_hit[DCI_D_CELL];
  assign set_vec[DCI_F_ABORT] = abort_done;
  assign set_vec[DCI_F_ADDR_ERR] = evt_i.addr_err | (evt_i.start & ssa_bad);

  // Write one clears; a same-cycle event wins
  assign clr_vec = wr_irq ? bus_i.wdata[DCI_FLAG_LSB +: DCI_NFLAG] : 8'h00;
  assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

  assign irq_o = |(flags_r & en_r);
  assign rdata_o = rdata_r;
  assign ssa_o = ssa_r;
  assign ssiz_o = ssiz_r;
  assign dsiz_o = dsiz_r;
  assign csiz_o = csiz_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= DCI_FLAG_RST;
      en_r <= DCI_EN_RST;
      rdata_r <= 32'h0000_0000;
      state_r <= DCI_ST_IDLE;
    end else if (ce_i) begin
      flags_r <= flags_nxt;
      en_r <= en_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ssa_r <= DCI_SSA_RST;
      ssiz_r <= DCI_SIZE_RST;
      dsiz_r <= DCI_SIZE_RST;
      csiz_r <= DCI_SIZE_RST;
      anum_r <= DCI_ANUM_RST;
      aen_r <= DCI_AEN_RST;
    end else if (ce_i) begin
      ssa_r <= ssa_nxt;
      ssiz_r <= ssiz_nxt;
      dsiz_r <= dsiz_nxt;
      csiz_r <= csiz_nxt;
      anum_r <= anum_nxt;
      aen_r <= aen_nxt;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_rsvd_bytes_zero: assert property (
    ce_i && bus_i.rd && sel_irq |=> rdata_o[31:24] == 8'h00 && rdata_o[15:8] == 8'h00
  ) else $error("reserved bytes of irq control read nonzero");

  chk_enable_write: assert property (
    ce_i && wr_irq |=> en_r == $past(bus_i.wdata[23:16]) && rdata_o == 32'h0000_0000
  ) else $error("enable bits not loaded from write");

  chk_src_done_set: assert property (
    ce_i && evt_i.src_step && evt_i.src_ptr == ssiz_r && !g_det[0].u_det.eq_prev_r
    |=> flags_r[DCI_F_SRC_DONE]
  ) else $error("source done flag missed");

  chk_src_half_set: assert property (
    det_hit[DCI_D_SRC_HALF] |-> evt_i.src_ptr == {1'b0, ssiz_r[15:1]}
    ##1 flags_r[DCI_F_SRC_HALF]
  ) else $error("source half flag wrong");

  chk_dst_done_set: assert property (
    det_hit[DCI_D_DST_DONE] |-> evt_i.dst_ptr == dsiz_r ##1 flags_r[DCI_F_DST_DONE]
  ) else $error("destination done flag wrong");

  chk_dst_half_set: assert property (
    det_hit[DCI_D_DST_HALF] |-> evt_i.dst_ptr == {1'b0, dsiz_r[15:1]}
    ##1 flags_r[DCI_F_DST_HALF]
  ) else $error("destination half flag wrong");

  chk_block_pattern: assert property (
    ce_i && (evt_i.pat_match || (det_hit[DCI_D_BLOCK] &&
    evt_i.blk_cnt >= ssiz_r && evt_i.blk_cnt >= dsiz_r)) |=> flags_r[DCI_F_BLOCK]
  ) else $error("block complete flag missed");

  chk_cell_set: assert property (
    det_hit[DCI_D_CELL] |-> evt_i.cell_ptr == csiz_r ##1 flags_r[DCI_F_CELL]
  ) else $error("cell complete flag wrong");

  chk_abort_flag: assert property (
    ce_i && abort_req_o && !evt_i.busy |=> flags_r[DCI_F_ABORT] && !abort_req_o
  ) else $error("abort flag not set after abort");

  chk_addr_error: assert property (
    ce_i && evt_i.addr_err |=> flags_r[DCI_F_ADDR_ERR]
  ) else $error("address error flag missed");

  chk_ssa_write: assert property (
    ce_i && bus_i.wr && sel_ssa |=> ssa_o == $past(bus_i.wdata)
  ) else $error("source start address not written");

  chk_set_wins: assert property (
    ce_i && wr_irq && bus_i.wdata[DCI_F_CELL] && det_hit[DCI_D_CELL]
    |=> flags_r[DCI_F_CELL] && (irq_o || !en_r[DCI_F_CELL])
  ) else $error("event lost against clear");

  chk_flag_sticky: assert property (
    ce_i && !wr_irq |=> (flags_r & $past(flags_r)) == $past(flags_r)
  ) else $error("flag dropped without software clear");

  chk_abort_gate: assert property (
    ce_i && evt_i.irq_valid && evt_i.irq_num == anum_r && evt_i.busy
    |=> abort_req_o == $past(aen_r)
  ) else $error("abort irq gating wrong");

  chk_ssa_read: assert property (
    ce_i && bus_i.rd && sel_ssa |=> rdata_o == $past(ssa_r)
  ) else $error("source start address read wrong");

  chk_size_read: assert property (
    ce_i && bus_i.rd && sel_ssiz |=> rdata_o == {16'h0000, $past(ssiz_r)}
  ) else $error("source size read wrong");

  chk_read_stands: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 32'h0000_0000
  ) else $error("read data held past its cycle");

  chk_start_bad_addr: assert property (
    ce_i && evt_i.start && ssa_r > DCI_ADDR_HI |=> flags_r[DCI_F_ADDR_ERR]
  ) else $error("invalid start address not flagged");

  chk_block_target: assert property (
    det_hit[DCI_D_BLOCK] |-> evt_i.blk_cnt >= ssiz_r && evt_i.blk_cnt >= dsiz_r
  ) else $error("block flag before larger size");

  chk_flag_clear: assert property (
    ce_i && wr_irq && bus_i.wdata[DCI_F_ADDR_ERR] && !set_vec[DCI_F_ADDR_ERR]
    |=> !flags_r[DCI_F_ADDR_ERR]
  ) else $error("write one did not clear flag");

  chk_abort_off: assert property (
    ce_i && !aen_r && !abort_req_o |=> !abort_req_o
  ) else $error("abort raised while disabled");

  chk_abort_holds: assert property (
    ce_i && abort_req_o && evt_i.busy |=> abort_req_o
  ) else $error("abort request dropped while busy");

  chk_ce_freeze: assert property (
    !ce_i |=> $stable(ssa_r) && $stable(flags_r) && $stable(en_r)
  ) else $error("state moved with clock enable low");

  cov_abort_done: cover property (abort_req_o ##[1:20] flags_r[DCI_F_ABORT]);
  cov_set_wins: cover property (ce_i && wr_irq && |(bus_i.wdata[7:0] & set_vec));
  cov_src_irq: cover property (flags_r[DCI_F_SRC_DONE] && irq_o);
  cov_clear: cover property (ce_i && wr_irq && |(flags_r & bus_i.wdata[7:0]));
  cov_pattern: cover property (ce_i && evt_i.pat_match);
endmodule : dci_channel_irq

/* File: test/dci_channel_irq_tb.sv */
`timescale 1ns/10ps
module testbench;
  import dci_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  dci_bus_t bus_i = '0;
  dci_evt_t evt_i = '0;
  logic [31:0] rdata_o;
  logic [31:0] ssa_o;
  logic [15:0] ssiz_o;
  logic [15:0] dsiz_o;
  logic [15:0] csiz_o;
  logic abort_req_o;
  logic irq_o;
  logic [31:0] rd_v;
  int num_errors = 0;
  int num_checks = 0;
  // Comparator table: step kind, target pointer, flag bit
  int tk[6] = '{0, 0, 1, 1, 2, 3};
  logic [15:0] tv[6] = '{16'h0008, 16'h0010, 16'h0010, 16'h0020, 16'h0004, 16'h0020};
  int tb[6] = '{6, 7, 4, 5, 2, 3};

  always #2.5 clock_i = ~clock_i;

  dci_channel_irq DUT (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .evt_i(evt_i),
    .ssa_o(ssa_o),
    .ssiz_o(ssiz_o),
    .dsiz_o(dsiz_o),
    .csiz_o(csiz_o),
    .abort_req_o(abort_req_o),
    .irq_o(irq_o)
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_i.wr <= 1'b1;
    bus_i.addr <= a;
    bus_i.wdata <= d;
    @(posedge clock_i);
    bus_i.wr <= 1'b0;
    #1;
  endtask : bw

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    bus_i.rd <= 1'b1;
    bus_i.addr <= a;
    @(posedge clock_i);
    bus_i.rd <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rchk

  // Kinds: 0 src, 1 dst, 2 cell, 3 block, 4 pattern, 5 addr err, 6 start, 7 irq
  task automatic ev(input int k, input logic [15:0] v);
    @(posedge clock_i);
    evt_i.src_ptr <= v;
    evt_i.dst_ptr <= v;
    evt_i.cell_ptr <= v;
    evt_i.blk_cnt <= v;
    evt_i.irq_num <= v[7:0];
    case (k)
      0: evt_i.src_step <= 1'b1;
      1: evt_i.dst_step <= 1'b1;
      2: evt_i.cell_step <= 1'b1;
      3: evt_i.blk_step <= 1'b1;
      4: evt_i.pat_match <= 1'b1;
      5: evt_i.addr_err <= 1'b1;
      6: evt_i.start <= 1'b1;
      default: evt_i.irq_valid <= 1'b1;
    endcase
    @(posedge clock_i);
    evt_i.src_step <= 1'b0;
    evt_i.dst_step <= 1'b0;
    evt_i.cell_step <= 1'b0;
    evt_i.blk_step <= 1'b0;
    evt_i.pat_match <= 1'b0;
    evt_i.addr_err <= 1'b0;
    evt_i.start <= 1'b0;
    evt_i.irq_valid <= 1'b0;
    #1;
  endtask : ev

  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rchk(DCI_OFF_IRQ, 32'h0000_0000);
    rchk(DCI_OFF_SSA, 32'h0000_0000);
    chk(ssa_o, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0);
    bw(DCI_OFF_SSA, 32'h1234_5678);
    chk(ssa_o, 32'h1234_5678);
    rchk(DCI_OFF_SSA, 32'h1234_5678);
    @(posedge clock_i);
    ce_i <= 1'b0;
    bw(DCI_OFF_SSA, 32'hdead_beef);
    @(posedge clock_i);
    ce_i <= 1'b1;
    #1;
    chk(ssa_o, 32'h1234_5678);
    rchk(8'h18, 32'h0000_0000);
    bw(DCI_OFF_IRQ, 32'hffff_ffff);
    rchk(DCI_OFF_IRQ, 32'h00ff_0000);
    @(posedge clock_i);
    #1;
    chk(rdata_o, 32'h0000_0000);
    bw(DCI_OFF_SSIZ, 32'hffff_ffff);
    rchk(DCI_OFF_SSIZ, 32'h0000_ffff);
    chk({16'h0, ssiz_o}, 32'h0000_ffff);
    bw(DCI_OFF_SSIZ, 32'h0000_0010);
    bw(DCI_OFF_DSIZ, 32'h0000_0020);
    bw(DCI_OFF_CSIZ, 32'h0000_0004);
    chk({16'h0, dsiz_o}, 32'h0000_0020);
    chk({16'h0, csiz_o}, 32'h0000_0004);
    // Top of the valid window must not flag an error
    bw(DCI_OFF_SSA, 32'h1fff_ffff);
    ev(6, 16'h0);
    rchk(DCI_OFF_IRQ, 32'h00ff_0000);
    for (int i = 0; i < 6; i++) begin
      ev(tk[i], tv[i] - 16'h1);
      ev(tk[i], tv[i]);
      rchk(DCI_OFF_IRQ, 32'h00ff_0000 | (32'h1 << tb[i]));
      chk({31'h0, irq_o}, 32'h1);
      bw(DCI_OFF_IRQ, 32'h00ff_00ff);
      chk({31'h0, irq_o}, 32'h0);
    end
    // Masking, pattern match and address errors
    bw(DCI_OFF_IRQ, 32'h0000_0000);
    ev(4, 16'h0);
    chk({31'h0, irq_o}, 32'h0);
    rchk(DCI_OFF_IRQ, 32'h0000_0008);
    bw(DCI_OFF_IRQ, 32'h00f7_0000);
    chk({31'h0, irq_o}, 32'h0);
    bw(DCI_OFF_IRQ, 32'h0008_0000);
    chk({31'h0, irq_o}, 32'h1);
    bw(DCI_OFF_IRQ, 32'h0001_00ff);
    chk({31'h0, irq_o}, 32'h0);
    ev(5, 16'h0);
    rchk(DCI_OFF_IRQ, 32'h0001_0001);
    chk({31'h0, irq_o}, 32'h1);
    bw(DCI_OFF_IRQ, 32'h0001_0001);
    bw(DCI_OFF_SSA, 32'h2000_0000);
    ev(6, 16'h0);
    rchk(DCI_OFF_IRQ, 32'h0001_0001);
    bw(DCI_OFF_IRQ, 32'h0002_00ff);
    // Abort on matching interrupt number
    bw(DCI_OFF_ACTL, 32'h0000_2a00);
    @(posedge clock_i);
    evt_i.busy <= 1'b1;
    ev(7, 16'h002a);
    chk({31'h0, abort_req_o}, 32'h0);
    bw(DCI_OFF_ACTL, 32'h0000_2a01);
    rchk(DCI_OFF_ACTL, 32'h0000_2a01);
    ev(7, 16'h002b);
    chk({31'h0, abort_req_o}, 32'h0);
    ev(7, 16'h002a);
    chk({31'h0, abort_req_o}, 32'h1);
    rchk(DCI_OFF_IRQ, 32'h0002_0000);
    @(posedge clock_i);
    evt_i.busy <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk({31'h0, abort_req_o}, 32'h0);
    rchk(DCI_OFF_IRQ, 32'h0002_0002);
    chk({31'h0, irq_o}, 32'h1);
    // Clear and cell event in one cycle: the event wins
    @(posedge clock_i);
    bus_i.wr <= 1'b1;
    bus_i.addr <= DCI_OFF_IRQ;
    bus_i.wdata <= 32'h0004_0006;
    evt_i.cell_step <= 1'b1;
    evt_i.cell_ptr <= 16'h0004;
    @(posedge clock_i);
    bus_i.wr <= 1'b0;
    evt_i.cell_step <= 1'b0;
    #1;
    chk({31'h0, irq_o}, 32'h1);
    rchk(DCI_OFF_IRQ, 32'h0004_0004);
    // Reset in mid-run clears address and flags
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    chk(ssa_o, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0);
    rchk(DCI_OFF_IRQ, 32'h0000_0000);
    end_of_test();
  end
endmodule : testbench
